//--- src/iop_port_bank.v
// GPIO port bank F and J with output/input peripheral remap and lock.
// Assumes Avalon-MM master on ref_clk; pins and peripheral inputs synchronous.
// How it works
// - Each remappable pin has a 4-bit output select choosing its peripheral.
// - Output select resets to zero, meaning no peripheral drives the pin.
// - Select writes while locked complete normally but change nothing.
// - Lock sits at bit 13 of system config; set blocks, clear permits.
// - Lock bit changes only on reset or on the first system config write after the two-word unlock sequence.
// - One-way option bit 29 keeps lock set until device reset.
// - One-way option defaults to set when unprogrammed.
// - Every writable port register has clear, set, invert aliases at +4, +8, +C; change status is read-only.
// - Unimplemented bits read zero; pin read and latch not reset.
// - Input select bits 3..0 pick the source pin; upper bits zero.
// - Output select field bits 3..0, reset zero, upper bits zero.
`timescale 1ns/1ps
`default_nettype none
`include "iop_defs.vh"
module iop_port_bank #(
   parameter NUM_OSEL  = 6,
   parameter NUM_ISEL  = 4,
   parameter NUM_PERIPH = 15,
   parameter [31:0] DEVCFG_DEFAULT = 32'hFFFF_FFFF
) (
   // Clock and reset
   input  wire                    ref_clk,
   input  wire                    rst,
   // Avalon-MM slave
   input  wire [11:0]             address,
   input  wire                    read,
   input  wire                    write,
   input  wire [31:0]             writedata,
   input  wire [3:0]              byteenable,
   output reg  [31:0]             readdata,
   output wire                    waitrequest,
   // Device configuration word
   input  wire [31:0]             devCfgWord,
   // Pins, port F and port J
   input  wire [31:0]             pinInF,
   input  wire [31:0]             pinInJ,
   output wire [31:0]             pinOutF,
   output wire [31:0]             pinOeF,
   output wire [31:0]             pinOutJ,
   output wire [31:0]             pinOeJ,
   output wire [31:0]             pullUpF,
   output wire [31:0]             pullDownF,
   output wire [31:0]             pullUpJ,
   output wire [31:0]             pullDownJ,
   output wire [31:0]             slew0F,
   output wire [31:0]             slew1F,
   output wire [31:0]             analogJ,
   // Peripheral remap
   input  wire [NUM_PERIPH*1-1:0] periphOut,
   output wire [NUM_ISEL-1:0]     periphIn,
   output wire                    remapLocked
);
   // Remappable pins are port F bits 0,1,3,4,5 and J bit 0 in this order
   localparam RP_W = 4;

   reg  [31:0] dirF, port_f_output_latch, port_f_open_drain, puF, pdF, cnCtlF, port_f_change_enable, port_f_change_status, port_f_falling_enable, cnFlagF, sr0F, sr1F;
   reg  [31:0] anselJ, dirJ, port_j_output_latch, port_j_open_drain, puJ, pdJ, cnCtlJ, port_j_change_enable, port_j_change_status, port_j_falling_enable, cnFlagJ;
   reg  [RP_W-1:0] oSel [0:NUM_OSEL-1];
   reg  [RP_W-1:0] iSel [0:NUM_ISEL-1];
   reg         lockBit;
   reg         oneWay;
   reg         oneWayLoaded;
   reg  [1:0]  unlockStep;
   reg  [31:0] prevF, prevJ;
   reg         ackPend;
   reg  [31:0] next_readdata;

   wire [11:0] baseAddr = {address[11:4], 4'h0};
   wire [1:0]  aliasSel = address[3:2];
   wire [31:0] beMask   = {{8{byteenable[3]}}, {8{byteenable[2]}}, {8{byteenable[1]}}, {8{byteenable[0]}}};
   wire        wrEn     = write & ~ackPend;
   wire        rdEn     = read & ~ackPend;

   // One wait cycle keeps read data registered
   assign waitrequest = (read | write) & ~ackPend;

   always @(posedge ref_clk or posedge rst) begin
      if (rst)
         ackPend <= 1'b0;
      else
         ackPend <= (read | write) & ~ackPend;
   end

   // Alias arithmetic on one register
   function [31:0] aliasWrite;
      input [31:0] cur;
      input [31:0] wd;
      input [1:0]  al;
      input [31:0] msk;
      input [31:0] bm;
      reg   [31:0] v;
      begin
         v = wd & bm;
         if (al == `IOP_ALIAS_CLR)
            aliasWrite = cur & ~(v & msk);
         else if (al == `IOP_ALIAS_SET)
            aliasWrite = cur | (v & msk);
         else if (al == `IOP_ALIAS_INV)
            aliasWrite = cur ^ (v & msk);
         else
            aliasWrite = ((cur & ~bm) | v) & msk;
      end
   endfunction

   // Select fields are 4 bits wide; the cut to the field is made here on purpose
   function [RP_W-1:0] selWrite;
      input [RP_W-1:0] cur;
      input [31:0]     wd;
      input [1:0]      al;
      input [31:0]     bm;
      reg   [31:0]     t;
      begin
         t        = aliasWrite({28'h0, cur}, wd, al, `IOP_MASK_SEL, bm);
         selWrite = t[RP_W-1:0];
      end
   endfunction

   // Strap is caught after reset release, never inside the async branch
   always @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         oneWay       <= 1'b1;
         oneWayLoaded <= 1'b0;
      end else if (!oneWayLoaded) begin
         oneWay       <= devCfgWord[`IOP_ONEWAY_BIT];
         oneWayLoaded <= 1'b1;
      end
   end

   // Lock and unlock key sequence
   wire wrSys    = wrEn && baseAddr == `IOP_OFF_SYSCFG;
   wire [31:0] sysNew = aliasWrite({18'h0, lockBit, 13'h0}, writedata, aliasSel, 32'h0000_2000, beMask);
   wire lockReq  = sysNew[`IOP_LOCK_BIT];
   always @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         lockBit    <= 1'b0;
         unlockStep <= 2'd0;
      end else if (wrEn && address == `IOP_OFF_UNLOCK) begin
         if (writedata == `IOP_KEY1)
            unlockStep <= 2'd1;
         else if (writedata == `IOP_KEY2 && unlockStep == 2'd1)
            unlockStep <= 2'd2;
         else
            unlockStep <= 2'd0;
      end else if (wrSys) begin
         unlockStep <= 2'd0;
         if (unlockStep == 2'd2) begin
            if (!(lockBit && oneWay && !lockReq))
               lockBit <= lockReq;
         end
      end
   end
   assign remapLocked = lockBit;

   // Remap select registers
   integer k;
   always @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         for (k = 0; k < NUM_OSEL; k = k + 1)
            oSel[k] <= {RP_W{1'b0}};
         for (k = 0; k < NUM_ISEL; k = k + 1)
            iSel[k] <= {RP_W{1'b0}};
      end else if (wrEn && !lockBit) begin
         for (k = 0; k < NUM_OSEL; k = k + 1)
            if (baseAddr == `IOP_OFF_OSEL_BASE + k[7:0] * 8'h10)
               oSel[k] <= selWrite(oSel[k], writedata, aliasSel, beMask);
         for (k = 0; k < NUM_ISEL; k = k + 1)
            if (baseAddr == `IOP_OFF_ISEL_BASE + k[7:0] * 8'h10)
               iSel[k] <= selWrite(iSel[k], writedata, aliasSel, beMask);
      end
   end

   // Port registers
   wire [31:0] mF = `IOP_MASK_F;
   wire [31:0] mJ = `IOP_MASK_J;
   always @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         dirF <= `IOP_RST_F_DIR;
         port_f_open_drain <= `IOP_RST_ZERO;
         puF <= `IOP_RST_ZERO;
         pdF <= `IOP_RST_ZERO;
         cnCtlF <= `IOP_RST_ZERO;
         port_f_change_enable <= `IOP_RST_ZERO;
         port_f_falling_enable <= `IOP_RST_ZERO;
         sr0F <= `IOP_RST_ZERO;
         sr1F <= `IOP_RST_ZERO;
         anselJ <= `IOP_RST_PORT_J_ANALOG_SELECT;
         dirJ <= `IOP_RST_J_DIR;
         port_j_open_drain <= `IOP_RST_ZERO;
         puJ <= `IOP_RST_ZERO;
         pdJ <= `IOP_RST_ZERO;
         cnCtlJ <= `IOP_RST_ZERO;
         port_j_change_enable <= `IOP_RST_ZERO;
         port_j_falling_enable <= `IOP_RST_ZERO;
      end else if (wrEn) begin
         // Masks keep unimplemented bits at zero on every write
         if (baseAddr == `IOP_OFF_F_DIR)        dirF   <= aliasWrite(dirF, writedata, aliasSel, mF, beMask);
         else if (baseAddr == `IOP_OFF_F_ODC)   port_f_open_drain   <= aliasWrite(port_f_open_drain, writedata, aliasSel, mF, beMask);
         else if (baseAddr == `IOP_OFF_F_PU)    puF    <= aliasWrite(puF, writedata, aliasSel, mF, beMask);
         else if (baseAddr == `IOP_OFF_F_PD)    pdF    <= aliasWrite(pdF, writedata, aliasSel, mF, beMask);
         else if (baseAddr == `IOP_OFF_F_CNCTL) cnCtlF <= aliasWrite(cnCtlF, writedata, aliasSel, `IOP_MASK_CNCTL, beMask);
         else if (baseAddr == `IOP_OFF_F_CNEN)  port_f_change_enable  <= aliasWrite(port_f_change_enable, writedata, aliasSel, mF, beMask);
         else if (baseAddr == `IOP_OFF_F_CNNE)  port_f_falling_enable  <= aliasWrite(port_f_falling_enable, writedata, aliasSel, mF, beMask);
         else if (baseAddr == `IOP_OFF_F_SR0)   sr0F   <= aliasWrite(sr0F, writedata, aliasSel, `IOP_MASK_SR, beMask);
         else if (baseAddr == `IOP_OFF_F_SR1)   sr1F   <= aliasWrite(sr1F, writedata, aliasSel, `IOP_MASK_SR, beMask);
         else if (baseAddr == `IOP_OFF_J_PORT_J_ANALOG_SELECT) anselJ <= aliasWrite(anselJ, writedata, aliasSel, `IOP_MASK_PORT_J_ANALOG_SELECT, beMask);
         else if (baseAddr == `IOP_OFF_J_DIR)   dirJ   <= aliasWrite(dirJ, writedata, aliasSel, mJ, beMask);
         else if (baseAddr == `IOP_OFF_J_ODC)   port_j_open_drain   <= aliasWrite(port_j_open_drain, writedata, aliasSel, mJ, beMask);
         else if (baseAddr == `IOP_OFF_J_PU)    puJ    <= aliasWrite(puJ, writedata, aliasSel, mJ, beMask);
         else if (baseAddr == `IOP_OFF_J_PD)    pdJ    <= aliasWrite(pdJ, writedata, aliasSel, mJ, beMask);
         else if (baseAddr == `IOP_OFF_J_CNCTL) cnCtlJ <= aliasWrite(cnCtlJ, writedata, aliasSel, `IOP_MASK_CNCTL, beMask);
         else if (baseAddr == `IOP_OFF_J_CNEN)  port_j_change_enable  <= aliasWrite(port_j_change_enable, writedata, aliasSel, mJ, beMask);
         else if (baseAddr == `IOP_OFF_J_CNNE)  port_j_falling_enable  <= aliasWrite(port_j_falling_enable, writedata, aliasSel, mJ, beMask);
      end
   end

   // Latches have no reset: contents undefined after reset
   always @(posedge ref_clk) begin
      if (wrEn && (baseAddr == `IOP_OFF_F_LAT || baseAddr == `IOP_OFF_F_PORT))
         port_f_output_latch <= aliasWrite(port_f_output_latch, writedata, aliasSel, mF, beMask);
      if (wrEn && (baseAddr == `IOP_OFF_J_LAT || baseAddr == `IOP_OFF_J_PORT))
         port_j_output_latch <= aliasWrite(port_j_output_latch, writedata, aliasSel, mJ, beMask);
   end

   // Change notice: mismatch or edge mode; hardware set wins over software clear
   wire [31:0] pinF = pinInF & mF;
   wire [31:0] pinJ = pinInJ & mJ;
   wire [31:0] chgF = cnCtlF[`IOP_CN_EDGE_BIT] ? ((pinF & ~prevF & port_f_change_enable) | (~pinF & prevF & port_f_falling_enable))
                                               : ((pinF ^ prevF) & port_f_change_enable);
   wire [31:0] chgJ = cnCtlJ[`IOP_CN_EDGE_BIT] ? ((pinJ & ~prevJ & port_j_change_enable) | (~pinJ & prevJ & port_j_falling_enable))
                                               : ((pinJ ^ prevJ) & port_j_change_enable);
   wire [31:0] evF  = cnCtlF[`IOP_CN_ON_BIT] ? chgF : 32'h0000_0000;
   wire [31:0] evJ  = cnCtlJ[`IOP_CN_ON_BIT] ? chgJ : 32'h0000_0000;
   wire [31:0] flgWrF = (wrEn && baseAddr == `IOP_OFF_F_CNFLAG) ?
                        aliasWrite(cnFlagF, writedata, aliasSel, mF, beMask) : cnFlagF;
   wire [31:0] flgWrJ = (wrEn && baseAddr == `IOP_OFF_J_CNFLAG) ?
                        aliasWrite(cnFlagJ, writedata, aliasSel, mJ, beMask) : cnFlagJ;
   always @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         prevF <= `IOP_RST_ZERO;
         prevJ <= `IOP_RST_ZERO;
         port_f_change_status <= `IOP_RST_ZERO;
         port_j_change_status <= `IOP_RST_ZERO;
         cnFlagF <= `IOP_RST_ZERO;
         cnFlagJ <= `IOP_RST_ZERO;
      end else begin
         prevF <= pinF;
         prevJ <= pinJ;
         port_f_change_status <= (port_f_change_status | evF) & mF;
         port_j_change_status <= (port_j_change_status | evJ) & mJ;
         if (rdEn && baseAddr == `IOP_OFF_F_PORT) port_f_change_status <= evF;
         if (rdEn && baseAddr == `IOP_OFF_J_PORT) port_j_change_status <= evJ;
         cnFlagF <= flgWrF | evF;
         cnFlagJ <= flgWrJ | evJ;
      end
   end

   // Output mux: remapped peripheral replaces latch when select nonzero
   wire [31:0] rpMapF = {26'h0, 1'b1, 1'b1, 1'b1, 1'b0, 1'b1, 1'b1};
   wire [NUM_OSEL-1:0] rpDrv;
   wire [NUM_OSEL-1:0] rpVal;
   genvar g;
   generate
      for (g = 0; g < NUM_OSEL; g = g + 1) begin : gOut
         assign rpDrv[g] = (oSel[g] != 4'h0) && (oSel[g] <= NUM_PERIPH);
         assign rpVal[g] = rpDrv[g] ? periphOut[oSel[g] - 4'h1] : 1'b0;
      end
   endgenerate
   wire [31:0] remF  = {26'h0, rpVal[4], rpVal[3], rpVal[2], 1'b0, rpVal[1], rpVal[0]};
   wire [31:0] remFe = {26'h0, rpDrv[4], rpDrv[3], rpDrv[2], 1'b0, rpDrv[1], rpDrv[0]} & rpMapF;
   wire [31:0] remJ  = {31'h0, rpVal[5]};
   wire [31:0] remJe = {31'h0, rpDrv[5]};
   wire [31:0] valF  = (remFe & remF) | (~remFe & port_f_output_latch);
   wire [31:0] valJ  = (remJe & remJ) | (~remJe & port_j_output_latch);
   // Open drain releases on a one; enable low means driving
   assign pinOutF = valF & mF & ~port_f_open_drain;
   assign pinOeF  = ~(mF & ~dirF & ~(port_f_open_drain & valF));
   assign pinOutJ = valJ & mJ & ~port_j_open_drain;
   assign pinOeJ  = ~(mJ & ~dirJ & ~anselJ & ~(port_j_open_drain & valJ));
   assign pullUpF = puF;
   assign pullDownF = pdF;
   assign pullUpJ = puJ;
   assign pullDownJ = pdJ;
   assign slew0F = sr0F;
   assign slew1F = sr1F;
   assign analogJ = anselJ;

   // Input remap: source order F0,F1,F3,F4,F5,J0,J1,J2,J4
   wire [15:0] inSrc = {7'h0, pinJ[4], pinJ[2], pinJ[1], pinJ[0], pinF[5], pinF[4], pinF[3], pinF[1], pinF[0]};
   generate
      for (g = 0; g < NUM_ISEL; g = g + 1) begin : gIn
         assign periphIn[g] = inSrc[iSel[g]];
      end
   endgenerate

   // Read decode
   integer r;
   always @* begin
      next_readdata = `IOP_RST_ZERO;
      if (baseAddr == `IOP_OFF_F_DIR) next_readdata = dirF;
      else if (baseAddr == `IOP_OFF_F_PORT) next_readdata = pinF;
      else if (baseAddr == `IOP_OFF_F_LAT) next_readdata = port_f_output_latch & mF;
      else if (baseAddr == `IOP_OFF_F_ODC) next_readdata = port_f_open_drain;
      else if (baseAddr == `IOP_OFF_F_PU) next_readdata = puF;
      else if (baseAddr == `IOP_OFF_F_PD) next_readdata = pdF;
      else if (baseAddr == `IOP_OFF_F_CNCTL) next_readdata = cnCtlF;
      else if (baseAddr == `IOP_OFF_F_CNEN) next_readdata = port_f_change_enable;
      else if (baseAddr == `IOP_OFF_F_CNSTAT) next_readdata = port_f_change_status;
      else if (baseAddr == `IOP_OFF_F_CNNE) next_readdata = port_f_falling_enable;
      else if (baseAddr == `IOP_OFF_F_CNFLAG) next_readdata = cnFlagF;
      else if (baseAddr == `IOP_OFF_F_SR0) next_readdata = sr0F;
      else if (baseAddr == `IOP_OFF_F_SR1) next_readdata = sr1F;
      else if (baseAddr == `IOP_OFF_J_PORT_J_ANALOG_SELECT) next_readdata = anselJ;
      else if (baseAddr == `IOP_OFF_J_DIR) next_readdata = dirJ;
      else if (baseAddr == `IOP_OFF_J_PORT) next_readdata = pinJ;
      else if (baseAddr == `IOP_OFF_J_LAT) next_readdata = port_j_output_latch & mJ;
      else if (baseAddr == `IOP_OFF_J_ODC) next_readdata = port_j_open_drain;
      else if (baseAddr == `IOP_OFF_J_PU) next_readdata = puJ;
      else if (baseAddr == `IOP_OFF_J_PD) next_readdata = pdJ;
      else if (baseAddr == `IOP_OFF_J_CNCTL) next_readdata = cnCtlJ;
      else if (baseAddr == `IOP_OFF_J_CNEN) next_readdata = port_j_change_enable;
      else if (baseAddr == `IOP_OFF_J_CNSTAT) next_readdata = port_j_change_status;
      else if (baseAddr == `IOP_OFF_J_CNNE) next_readdata = port_j_falling_enable;
      else if (baseAddr == `IOP_OFF_J_CNFLAG) next_readdata = cnFlagJ;
      else if (baseAddr == `IOP_OFF_SYSCFG) next_readdata = {18'h0, lockBit, 13'h0};
      for (r = 0; r < NUM_OSEL; r = r + 1)
         if (baseAddr == `IOP_OFF_OSEL_BASE + r[7:0] * 8'h10)
            next_readdata = {28'h0, oSel[r]};
      for (r = 0; r < NUM_ISEL; r = r + 1)
         if (baseAddr == `IOP_OFF_ISEL_BASE + r[7:0] * 8'h10)
            next_readdata = {28'h0, iSel[r]};
   end

   always @(posedge ref_clk or posedge rst) begin
      if (rst)
         readdata <= `IOP_RST_ZERO;
      else if (rdEn)
         readdata <= next_readdata;
   end
endmodule // iop_port_bank
`default_nettype wire

//--- src/iop_defs.vh
// Constants for the remappable GPIO port bank.
// Included by the design module; definitions only.
`ifndef IOP_DEFS_VH
`define IOP_DEFS_VH
`define IOP_OFF_F_DIR     12'h510
`define IOP_OFF_F_PORT    12'h520
`define IOP_OFF_F_LAT     12'h530
`define IOP_OFF_F_ODC     12'h540
`define IOP_OFF_F_PU      12'h550
`define IOP_OFF_F_PD      12'h560
`define IOP_OFF_F_CNCTL   12'h570
`define IOP_OFF_F_CNEN    12'h580
`define IOP_OFF_F_CNSTAT  12'h590
`define IOP_OFF_F_CNNE    12'h5A0
`define IOP_OFF_F_CNFLAG  12'h5B0
`define IOP_OFF_F_SR0     12'h5C0
`define IOP_OFF_F_SR1     12'h5D0
`define IOP_OFF_J_PORT_J_ANALOG_SELECT   12'h800
`define IOP_OFF_J_DIR     12'h810
`define IOP_OFF_J_PORT    12'h820
`define IOP_OFF_J_LAT     12'h830
`define IOP_OFF_J_ODC     12'h840
`define IOP_OFF_J_PU      12'h850
`define IOP_OFF_J_PD      12'h860
`define IOP_OFF_J_CNCTL   12'h870
`define IOP_OFF_J_CNEN    12'h880
`define IOP_OFF_J_CNSTAT  12'h890
`define IOP_OFF_J_CNNE    12'h8A0
`define IOP_OFF_J_CNFLAG  12'h8B0
`define IOP_OFF_SYSCFG    12'h900
`define IOP_OFF_UNLOCK    12'h910
`define IOP_OFF_OSEL_BASE 12'hA00
`define IOP_OFF_ISEL_BASE 12'hB00
`define IOP_ALIAS_CLR     2'd1
`define IOP_ALIAS_SET     2'd2
`define IOP_ALIAS_INV     2'd3
`define IOP_MASK_F        32'h0000_003B
`define IOP_MASK_J        32'h0000_0B17
`define IOP_MASK_PORT_J_ANALOG_SELECT    32'h0000_0B00
`define IOP_MASK_SR       32'h0000_0003
`define IOP_MASK_CNCTL    32'h0000_8800
`define IOP_MASK_SEL      32'h0000_000F
`define IOP_RST_F_DIR     32'h0000_003B
`define IOP_RST_J_DIR     32'h0000_0B17
`define IOP_RST_PORT_J_ANALOG_SELECT     32'h0000_0B00
`define IOP_RST_ZERO      32'h0000_0000
`define IOP_LOCK_BIT      13
`define IOP_ONEWAY_BIT    29
`define IOP_KEY1          32'hAA99_6655
`define IOP_KEY2          32'h5566_99AA
`define IOP_CN_ON_BIT     15
`define IOP_CN_EDGE_BIT   11
`endif

//--- dv/iop_port_bank_monitor.sv
// Checker for the remap port bank: bus timing, lock cause, select readback.
// Sees only top ports; devCfgWord is held steady while out of reset.
`timescale 1ns/1ps
`default_nettype none
module iop_port_bank_monitor (
   // Clock and reset
   input wire logic        ref_clk,
   input wire logic        rst,
   // Bus
   input wire logic [11:0] address,
   input wire logic        read,
   input wire logic        write,
   input wire logic [31:0] readdata,
   input wire logic        waitrequest,
   // Lock
   input wire logic [31:0] devCfgWord,
   input wire logic        remapLocked
);
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (rst);
   a_wait_first: assert property ($rose(read || write) |-> waitrequest) else $error("no wait on first cycle");
   a_wait_once: assert property ((read || write) && waitrequest |=> !waitrequest) else $error("wait too long");
   a_lock_cause: assert property ($changed(remapLocked)
      |-> $past(write) && (($past(address) & 12'hFF0) == 12'h900)) else $error("lock moved without config write");
   a_oneway_hold: assert property (devCfgWord[29] && $past(remapLocked) |-> remapLocked)
      else $error("one-way lock released");
   a_unmapped_zero: assert property (read && !waitrequest && address == 12'hF00 |-> readdata == 32'h0000_0000)
      else $error("unmapped read not zero");
   a_osel_upper: assert property (read && !waitrequest && address[11:8] == 4'hA && address[3:0] == 4'h0
      |-> readdata[31:4] == 28'h000_0000) else $error("output select upper bits set");
   a_isel_upper: assert property (read && !waitrequest && address[11:8] == 4'hB && address[3:0] == 4'h0
      |-> readdata[31:4] == 28'h000_0000) else $error("input select upper bits set");
   a_lock_read: assert property (read && !waitrequest && address == 12'h900 |-> readdata[13] == remapLocked)
      else $error("lock readback wrong");
endmodule // iop_port_bank_monitor
bind iop_port_bank iop_port_bank_monitor i_iop_port_bank_monitor (.ref_clk(ref_clk), .rst(rst), .address(address),
   .read(read), .write(write), .readdata(readdata), .waitrequest(waitrequest), .devCfgWord(devCfgWord),
   .remapLocked(remapLocked));
`default_nettype wire

//--- dv/iop_pin_model.sv
// Pads and peripherals beside the port bank.
// External drivers always drive; a pull wins over them when the pad is released.
`timescale 1ns/1ps
`default_nettype none
module iop_pin_model (
   // Pad side of the bank
   input  wire logic [31:0] pinOutF,
   input  wire logic [31:0] pinOeF,
   input  wire logic [31:0] pinOutJ,
   input  wire logic [31:0] pinOeJ,
   input  wire logic [31:0] pullUpF,
   input  wire logic [31:0] pullDownF,
   input  wire logic [31:0] pullUpJ,
   input  wire logic [31:0] pullDownJ,
   // Outside world
   input  wire logic [31:0] extF,
   input  wire logic [31:0] extJ,
   input  wire logic [14:0] periphDrive,
   output wire logic [31:0] pinInF,
   output wire logic [31:0] pinInJ,
   output wire logic [14:0] periphOut
);
   // Low enable drives the pad
   assign pinInF = (~pinOeF & pinOutF) | (pinOeF & (pullUpF | (extF & ~pullDownF)));
   assign pinInJ = (~pinOeJ & pinOutJ) | (pinOeJ & (pullUpJ | (extJ & ~pullDownJ)));
   assign periphOut = periphDrive;
endmodule // iop_pin_model
`default_nettype wire

//--- dv/test_iop_port_bank.sv
// Self-checking bench for the remap port bank.
// Assumes one 40 MHz clock; Avalon-MM master with full byte lanes.
`timescale 1ns/1ps
`default_nettype none
`include "iop_defs.vh"
module test_iop_port_bank;
   logic        ref_clk     = 1'b0;
   logic        rst         = 1'b1;
   logic [11:0] address     = 12'h000;
   logic        read        = 1'b0;
   logic        write       = 1'b0;
   logic [31:0] writedata   = 32'h0000_0000;
   logic [31:0] devCfgWord  = 32'hFFFF_FFFF;
   logic [31:0] extF        = 32'h0000_0000;
   logic [31:0] extJ        = 32'h0000_0000;
   logic [14:0] periphDrive = 15'h0004;
   logic [31:0] readdata, pinInF, pinInJ, pinOutF, pinOeF, pinOutJ, pinOeJ, rd;
   logic [31:0] pullUpF, pullDownF, pullUpJ, pullDownJ;
   logic [14:0] periphOut;
   logic [3:0]  periphIn;
   logic        waitrequest, remapLocked;
   int          n_fail      = 0;
   int          n_checks    = 0;
   logic [11:0] ra [16] = '{12'h510, 12'h540, 12'h550, 12'h560, 12'h570, 12'h580, 12'h590, 12'h5A0,
                            12'h5B0, 12'h5C0, 12'h5D0, 12'h800, 12'h810, 12'h8B0, 12'hA50, 12'hF00};
   logic [31:0] rv [16] = '{32'h0000_003B, 0, 0, 0, 0, 0, 0, 0, 0, 0, 0, 32'h0000_0B00, 32'h0000_0B17, 0, 0, 0};
   logic [11:0] aa [7]  = '{12'h540, 12'h544, 12'h548, 12'h54C, 12'h548, 12'h84C, 12'h844};
   logic [31:0] ad [7]  = '{32'h0000_003F, 32'h0000_0003, 32'h0000_0004, 32'h0000_0011, 32'h0000_0002,
                            32'hFFFF_FFFF, 32'h0000_0100};
   logic [31:0] ae [7]  = '{32'h0000_003B, 32'h0000_0038, 32'h0000_0038, 32'h0000_0029, 32'h0000_002B,
                            32'h0000_0B17, 32'h0000_0A17};
   always #12.5 ref_clk = ~ref_clk;
   iop_port_bank i_iop_port_bank (.ref_clk(ref_clk), .rst(rst), .address(address), .read(read), .write(write),
      .writedata(writedata), .byteenable(4'hF), .readdata(readdata), .waitrequest(waitrequest),
      .devCfgWord(devCfgWord), .pinInF(pinInF), .pinInJ(pinInJ), .pinOutF(pinOutF), .pinOeF(pinOeF),
      .pinOutJ(pinOutJ), .pinOeJ(pinOeJ), .pullUpF(pullUpF), .pullDownF(pullDownF), .pullUpJ(pullUpJ),
      .pullDownJ(pullDownJ), .slew0F(), .slew1F(), .analogJ(), .periphOut(periphOut), .periphIn(periphIn),
      .remapLocked(remapLocked));
   iop_pin_model i_iop_pin_model (.pinOutF(pinOutF), .pinOeF(pinOeF), .pinOutJ(pinOutJ), .pinOeJ(pinOeJ),
      .pullUpF(pullUpF), .pullDownF(pullDownF), .pullUpJ(pullUpJ), .pullDownJ(pullDownJ), .extF(extF),
      .extJ(extJ), .periphDrive(periphDrive), .pinInF(pinInF), .pinInJ(pinInJ), .periphOut(periphOut));
   task automatic stop_test;
      if (n_fail == 0 && n_checks > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         n_fail++;
         $display("ERROR %s expected %h seen %h", what, exp, seen);
      end
   endtask
   // Request held up to the rising edge that samples waitrequest low, then one idle edge
   task automatic bus(input logic wr, input logic [11:0] a, input logic [31:0] d);
      int n;
      n = 0;
      address <= a;
      writedata <= d;
      read <= !wr;
      write <= wr;
      do begin
         @(posedge ref_clk);
         n++;
      end while (waitrequest !== 1'b0 && n < 50);
      if (n >= 50)
         n_fail++;
      rd = readdata;
      read <= 1'b0;
      write <= 1'b0;
      @(posedge ref_clk);
   endtask
   task automatic rchk(input string what, input logic [11:0] a, input logic [31:0] exp);
      bus(1'b0, a, 32'h0000_0000);
      check(what, rd, exp);
   endtask
   task automatic unlock(input logic [31:0] v);
      bus(1'b1, 12'h910, `IOP_KEY1);
      bus(1'b1, 12'h910, `IOP_KEY2);
      bus(1'b1, 12'h900, v);
   endtask
   task automatic do_reset(input logic [31:0] cfg);
      rst <= 1'b1;
      devCfgWord <= cfg;
      repeat (8) @(posedge ref_clk);
      rst <= 1'b0;
      repeat (2) @(posedge ref_clk);
   endtask
   initial begin
      #200_000;
      n_fail++;
      stop_test();
   end
   initial begin
      do_reset(32'hFFFF_FFFF);
      for (int i = 0; i < 16; i++)
         rchk("reset value", ra[i], rv[i]);
      check("lock after reset", {31'h0, remapLocked}, 0);
      bus(1'b1, 12'h530, 32'h0000_0000);
      bus(1'b1, 12'h514, 32'h0000_0001);
      rchk("direction after clear", 12'h510, 32'h0000_003A);
      check("null select drives latch", {31'h0, pinOutF[0]}, 0);
      bus(1'b1, 12'hA00, 32'hFFFF_FFF3);
      rchk("output select", 12'hA00, 32'h0000_0003);
      check("peripheral 3 on pin", {31'h0, pinOutF[0]}, 1);
      check("pad level", {31'h0, pinInF[0]}, 1);
      bus(1'b1, 12'hA00, 32'h0000_0002);
      check("peripheral 2 on pin", {31'h0, pinOutF[0]}, 0);
      bus(1'b1, 12'hB00, 32'hFFFF_FFF3);
      rchk("input select", 12'hB00, 32'h0000_0003);
      extF <= 32'h0000_0010;
      @(posedge ref_clk);
      check("input from pin high", {31'h0, periphIn[0]}, 1);
      extF <= 32'h0000_0000;
      @(posedge ref_clk);
      check("input from pin low", {31'h0, periphIn[0]}, 0);
      unlock(32'h0000_2000);
      check("lock set", {31'h0, remapLocked}, 1);
      rchk("lock readback", 12'h900, 32'h0000_2000);
      bus(1'b1, 12'hA00, 32'h0000_0005);
      rchk("locked output select", 12'hA00, 32'h0000_0002);
      bus(1'b1, 12'hB00, 32'h0000_0001);
      rchk("locked input select", 12'hB00, 32'h0000_0003);
      bus(1'b1, 12'h900, 32'h0000_0000);
      check("clear without unlock", {31'h0, remapLocked}, 1);
      unlock(32'h0000_0000);
      check("one-way keeps lock", {31'h0, remapLocked}, 1);
      for (int i = 0; i < 7; i++) begin
         bus(1'b1, aa[i], ad[i]);
         rchk("alias result", aa[i] & 12'hFF0, ae[i]);
      end
      do_reset(32'h0000_0000);
      check("reset clears lock", {31'h0, remapLocked}, 0);
      rchk("select after reset", 12'hA00, 32'h0000_0000);
      unlock(32'h0000_2000);
      check("second lock", {31'h0, remapLocked}, 1);
      unlock(32'h0000_0000);
      check("lock cleared", {31'h0, remapLocked}, 0);
      bus(1'b1, 12'hA00, 32'h0000_0004);
      rchk("unlocked select", 12'hA00, 32'h0000_0004);
      stop_test();
   end
endmodule // test_iop_port_bank
`default_nettype wire
